// ===== hdl/acr_pkg.sv
package acr_pkg;
    localparam int RESULT_W = 16;
    localparam int CODE_W = 17;
    localparam int FRAME_W = 24;
    localparam int CHAN_W = 1;
    localparam int ENTRY_W = RESULT_W + CHAN_W;
    localparam int FIFO_DEPTH = 32;
    localparam logic [RESULT_W-1:0] RESULT_ONES = 16'hFFFF;
    localparam logic [RESULT_W-1:0] CODE_FULL = 16'hFFFF;
    localparam logic [RESULT_W-1:0] CODE_MID = 16'h8000;
    localparam logic [FRAME_W-1:0] FRAME_ONES = 24'hFFFFFF;
    localparam logic [6:0] TRAIL_ZEROS = 7'h00;
    localparam int TAG_POS = 7;
    localparam int CHAIN_IN_PLAIN = 8;
    localparam int CHAIN_IN_TAG = 0;
    localparam int EOS_CONVERSION_CLOCK_INTERNAL_COUNT = 3;
    localparam int SCLK_PER_CONVERSION_CLOCK_INTERNAL = 2;
    localparam int OSC_DIV = 4;
    localparam int CLK_PERIOD_NS = 100;
    localparam int QUIET_NS = 20;
    localparam int QUIET_CYCLES = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        ACR_IDLE = 2'b01,
        ACR_FRAME = 2'b10
    } acr_frame_t;
    typedef enum logic [1:0] {
        ACR_TRG_WAIT = 2'b01,
        ACR_TRG_COUNT = 2'b10
    } acr_trig_t;
endpackage

// ===== hdl/acr_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module acr_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 32
) (
    input wire logic clk,               // System clock
    input wire logic rst,               // Async reset, active high
    input wire logic clr,               // Sync flush
    input wire logic in_valid,          // Write request
    output logic in_ready,              // Space available
    input wire logic [WIDTH-1:0] in_data, // Write data
    output logic out_valid,             // Data available
    input wire logic out_ready,         // Read accept
    output logic [WIDTH-1:0] out_data   // Read data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic push;
    logic pop;

    assign out_valid = (wr_ptr_ff != rd_ptr_ff);
    assign in_ready = (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]) || (wr_ptr_ff[AW] == rd_ptr_ff[AW]);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_ff[AW-1:0]];

    // Storage has no reset; only the pointers define what is valid
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else if (clr) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== hdl/acr_readout.sv
`timescale 1ns/10ps
`default_nettype none
module acr_readout #(
    parameter int FIFO_DEPTH = acr_pkg::FIFO_DEPTH,
    parameter int OSC_DIV = acr_pkg::OSC_DIV
) (
    input wire logic clk,                               // 10 MHz system clock
    input wire logic rst,                               // Power-on reset, async, high
    input wire logic sclk,                              // Host serial clock
    input wire logic frame_sync_input,                  // Chip select / frame sync, low active
    input wire logic convert_start_n,                   // Manual conversion start, low
    input wire logic status_in,                         // Status pin input level
    output logic status_out,                            // Status pin output level
    output logic status_oe_n,                           // Status pin drive enable, low
    output logic sdo_out,                               // Serial data out level
    output logic sdo_oe_n,                              // Serial data drive enable, low
    input wire logic chain_enable_bit,                  // 0 selects chain mode
    input wire logic tag_enable_bit,                    // 1 appends channel tag
    input wire logic manual_trigger_bit,                // 1 manual, 0 auto trigger
    input wire logic osc_clock_bit,                     // 1 oscillator, 0 sclk/2
    input wire logic software_reset_bit,                // 0 requests reset
    input wire logic result_valid,                      // Conversion done with code
    output logic result_ready,                          // Result buffer has space
    input wire logic [acr_pkg::CODE_W-1:0] result_code, // Raw converter code
    input wire logic result_channel,                    // Channel of this code
    output logic sampling_end                           // Sampling end point pulse
);
    ////////////////////////////////////////////////////////////////////////////
    logic soft_rst;
    logic cs_prev_ff;
    logic sclk_prev_ff;
    logic cst_prev_ff;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic chain_mode;
    logic conversion_clock_internal_tick;
    logic [acr_pkg::RESULT_W-1:0] sat_code;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [acr_pkg::ENTRY_W-1:0] fifo_out;
    logic [acr_pkg::RESULT_W-1:0] held_ff;
    logic held_chan_ff;
    logic first_frame_ff;
    logic done_flag_ff;
    logic cdi_ff;
    logic [acr_pkg::FRAME_W-1:0] shreg_ff;
    logic [acr_pkg::FRAME_W-1:0] nxt_shreg;
    acr_pkg::acr_frame_t frame_st_ff;
    acr_pkg::acr_trig_t trig_st_ff;
    logic [1:0] eos_cnt_ff;
    logic [1:0] sdiv_ff;
    logic [$clog2(OSC_DIV)-1:0] odiv_ff;
    logic sdo_ff;
    logic sdo_oe_n_ff;
    logic status_ff;
    logic status_oe_n_ff;
    logic eos_ff;
    localparam int OCC_W = $clog2(FIFO_DEPTH) + 1;
    logic fifo_in_ready;
    logic push_ok;
    logic ready_ff;
    logic [OCC_W-1:0] occ_ff;
    logic [OCC_W-1:0] nxt_occ;

    // The soft reset clears the same state as rst except the edge detectors, dividers and pin drivers; it is a synchronous level
    assign soft_rst = !software_reset_bit;
    assign chain_mode = !chain_enable_bit;
    assign cs_fall = cs_prev_ff && !frame_sync_input;
    assign cs_rise = !cs_prev_ff && frame_sync_input;
    assign sclk_rise = !sclk_prev_ff && sclk;
    assign sclk_fall = sclk_prev_ff && !sclk;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_prev_ff <= 1'b1;
            sclk_prev_ff <= 1'b0;
            cst_prev_ff <= 1'b1;
        end else begin
            cs_prev_ff <= frame_sync_input;
            sclk_prev_ff <= sclk;
            cst_prev_ff <= convert_start_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result buffer: codes above full scale clamp to the top code
    assign sat_code = result_code[acr_pkg::CODE_W-1] ? acr_pkg::CODE_FULL
                                                     : result_code[acr_pkg::RESULT_W-1:0];

    // Held result only changes between frames, so a frame in progress keeps
    // the previous word; the buffer absorbs results arriving meanwhile
    assign fifo_pop = fifo_out_valid && (frame_st_ff == acr_pkg::ACR_IDLE);

    // Space flag is registered so the port comes from a flip-flop; the count
    // tracks the buffer pointers one for one
    assign push_ok = result_valid && ready_ff && fifo_in_ready;

    always_comb begin
        nxt_occ = occ_ff;
        if (push_ok && !fifo_pop) begin
            nxt_occ = occ_ff + 1'b1;
        end else if (fifo_pop && !push_ok) begin
            nxt_occ = occ_ff - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            occ_ff <= '0;
            ready_ff <= 1'b1;
        end else if (soft_rst) begin
            occ_ff <= '0;
            ready_ff <= 1'b1;
        end else begin
            occ_ff <= nxt_occ;
            ready_ff <= (nxt_occ != OCC_W'(FIFO_DEPTH));
        end
    end

    acr_fifo #(
        .WIDTH(acr_pkg::ENTRY_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .clr(soft_rst),
        .in_valid(push_ok),
        .in_ready(fifo_in_ready),
        .in_data({result_channel, sat_code}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            held_ff <= acr_pkg::RESULT_ONES;
            held_chan_ff <= 1'b1;
        end else if (soft_rst) begin
            held_ff <= acr_pkg::RESULT_ONES;
            held_chan_ff <= 1'b1;
        end else if (fifo_pop) begin
            held_ff <= fifo_out[acr_pkg::RESULT_W-1:0];
            held_chan_ff <= fifo_out[acr_pkg::ENTRY_W-1];
        end
    end

    // Done flag: a new result wins over the clear by a frame fall
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_flag_ff <= 1'b0;
        end else if (soft_rst) begin
            done_flag_ff <= 1'b0;
        end else if (fifo_pop) begin
            done_flag_ff <= 1'b1;
        end else if (cs_fall) begin
            done_flag_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion clock: sclk/2 only ticks while the host clocks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdiv_ff <= '0;
            odiv_ff <= '0;
        end else begin
            if (sclk_rise) begin
                sdiv_ff <= (sdiv_ff == 2'(acr_pkg::SCLK_PER_CONVERSION_CLOCK_INTERNAL - 1)) ? 2'h0 : sdiv_ff + 2'h1;
            end
            odiv_ff <= (odiv_ff == ($clog2(OSC_DIV))'(OSC_DIV - 1)) ? '0 : odiv_ff + 1'b1;
        end
    end

    assign conversion_clock_internal_tick = osc_clock_bit ? (odiv_ff == '0)
                                     : (sclk_rise && sdiv_ff == 2'h0);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_st_ff <= acr_pkg::ACR_TRG_WAIT;
            eos_cnt_ff <= '0;
            eos_ff <= 1'b0;
        end else if (soft_rst) begin
            trig_st_ff <= acr_pkg::ACR_TRG_WAIT;
            eos_cnt_ff <= '0;
            eos_ff <= 1'b0;
        end else begin
            eos_ff <= 1'b0;
            unique case (trig_st_ff)
                acr_pkg::ACR_TRG_WAIT: begin
                    eos_cnt_ff <= '0;
                    if (manual_trigger_bit && cst_prev_ff && !convert_start_n) begin
                        eos_ff <= 1'b1;
                    end else if (!manual_trigger_bit && result_valid) begin
                        trig_st_ff <= acr_pkg::ACR_TRG_COUNT;
                    end
                end
                acr_pkg::ACR_TRG_COUNT: begin
                    if (conversion_clock_internal_tick) begin
                        if (eos_cnt_ff == 2'(acr_pkg::EOS_CONVERSION_CLOCK_INTERNAL_COUNT - 1)) begin
                            eos_ff <= 1'b1;
                            trig_st_ff <= acr_pkg::ACR_TRG_WAIT;
                        end else begin
                            eos_cnt_ff <= eos_cnt_ff + 2'h1;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame
    always_comb begin
        nxt_shreg = shreg_ff;
        if (cs_fall) begin
            if (first_frame_ff) begin
                nxt_shreg = acr_pkg::FRAME_ONES;
            end else begin
                // Own result always leads; a reframe reloads it
                nxt_shreg = {held_ff, tag_enable_bit && held_chan_ff,
                             acr_pkg::TRAIL_ZEROS};
            end
        end else if (frame_st_ff == acr_pkg::ACR_FRAME && sclk_fall) begin
            nxt_shreg = {shreg_ff[acr_pkg::FRAME_W-2:0], first_frame_ff};
            if (chain_mode) begin
                // Insert point sets the pass-through delay to the read length
                if (tag_enable_bit) begin
                    nxt_shreg[acr_pkg::CHAIN_IN_TAG] = cdi_ff;
                end else begin
                    nxt_shreg[acr_pkg::CHAIN_IN_PLAIN] = cdi_ff;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_st_ff <= acr_pkg::ACR_IDLE;
            shreg_ff <= acr_pkg::FRAME_ONES;
            cdi_ff <= 1'b0;
        end else if (soft_rst) begin
            frame_st_ff <= acr_pkg::ACR_IDLE;
            shreg_ff <= acr_pkg::FRAME_ONES;
            cdi_ff <= 1'b0;
        end else begin
            shreg_ff <= nxt_shreg;
            if (sclk_rise && !frame_sync_input) begin
                cdi_ff <= status_in;
            end
            unique case (frame_st_ff)
                acr_pkg::ACR_IDLE: begin
                    if (cs_fall) begin
                        frame_st_ff <= acr_pkg::ACR_FRAME;
                    end
                end
                acr_pkg::ACR_FRAME: begin
                    if (cs_rise) begin
                        frame_st_ff <= acr_pkg::ACR_IDLE;
                    end
                end
            endcase
        end
    end

    // Ones persist only through the one frame that follows a reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            first_frame_ff <= 1'b1;
        end else if (soft_rst) begin
            first_frame_ff <= 1'b1;
        end else if (cs_rise && frame_st_ff == acr_pkg::ACR_FRAME) begin
            first_frame_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdo_ff <= 1'b0;
            sdo_oe_n_ff <= 1'b1;
        end else begin
            sdo_oe_n_ff <= frame_sync_input;
            sdo_ff <= frame_sync_input ? 1'b0 : nxt_shreg[acr_pkg::FRAME_W-1];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_ff <= 1'b0;
            status_oe_n_ff <= 1'b1;
        end else begin
            status_oe_n_ff <= chain_mode;
            status_ff <= chain_mode ? 1'b0 : done_flag_ff;
        end
    end

    assign sdo_out = sdo_ff;
    assign sdo_oe_n = sdo_oe_n_ff;
    assign status_out = status_ff;
    assign status_oe_n = status_oe_n_ff;
    assign sampling_end = eos_ff;
    assign result_ready = ready_ff;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence own_load_s;
        cs_fall && !first_frame_ff && !soft_rst;
    endsequence
    sequence framed_shift_s;
        frame_st_ff == acr_pkg::ACR_FRAME && sclk_fall && !cs_fall && !soft_rst;
    endsequence

    frame_load_a: assert property (own_load_s |=> shreg_ff[23:8] == $past(held_ff))
        else $error("own result not loaded at frame fall");
    trail_zero_a: assert property (own_load_s |=> shreg_ff[6:0] == 7'h00)
        else $error("trailing bits not zero");
    tag_bit_a: assert property (
        own_load_s ##0 tag_enable_bit |=> shreg_ff[7] == $past(held_chan_ff))
        else $error("tag bit wrong");
    first_ones_a: assert property (
        cs_fall && first_frame_ff && !soft_rst |=>
        shreg_ff == 24'hFFFFFF ##1 (sdo_ff || sdo_oe_n_ff))
        else $error("first frame not all ones");
    one_bit_a: assert property (
        framed_shift_s ##0 !chain_mode |=> shreg_ff[23:1] == $past(shreg_ff[22:0]))
        else $error("shift not one bit per clock");
    chain_in_a: assert property (
        framed_shift_s ##0 chain_mode && tag_enable_bit |=> shreg_ff[0] == $past(cdi_ff))
        else $error("chain input not inserted");
    sdo_release_a: assert property ($rose(frame_sync_input) |=> sdo_oe_n_ff && !sdo_ff)
        else $error("serial output not released");
    held_stable_a: assert property (
        frame_st_ff == acr_pkg::ACR_FRAME && !soft_rst |=> $stable(held_ff))
        else $error("held result changed inside frame");
    manual_eos_a: assert property (
        trig_st_ff == acr_pkg::ACR_TRG_WAIT && manual_trigger_bit && $fell(convert_start_n)
        && !soft_rst |=> eos_ff)
        else $error("no sampling end on convert start");
    soft_reset_a: assert property (
        soft_rst |=> held_ff == 16'hFFFF && first_frame_ff && frame_st_ff == acr_pkg::ACR_IDLE)
        else $error("software reset incomplete");
endmodule
`default_nettype wire

// ===== sim/acr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module acr_host_model (
    input wire logic clk,        // System clock
    output logic frame_n,        // Frame to device, low active
    output logic sclk,           // Serial clock to device
    output logic cdi_drive,      // Upstream chain data bit
    input wire logic sdo_out,    // Device serial data level
    input wire logic sdo_oe_n    // Device data drive enable, low
);
    wire logic sdo_line;
    // A released line floats, so a stale bit can never pass for data
    assign sdo_line = sdo_oe_n ? 1'bz : sdo_out;
    initial begin
        frame_n = 1'b1;
        sclk = 1'b0;
        cdi_drive = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic frame_start();
        wait_clk(1);
        frame_n = 1'b0;
        wait_clk(3);
    endtask
    // Three clocks per serial level; sclk stands still outside frames
    task automatic shift(input int n, input logic [47:0] chain_data_in, output logic [47:0] got);
        got = '0;
        cdi_drive = chain_data_in[47];
        wait_clk(1);
        for (int i = 0; i < n; i++) begin
            sclk = 1'b1;
            got[47-i] = sdo_line;
            wait_clk(3);
            sclk = 1'b0;
            if (i < 47) cdi_drive = chain_data_in[46-i];
            wait_clk(3);
        end
    endtask
    task automatic frame_stop();
        frame_n = 1'b1;
        cdi_drive = ~cdi_drive;
        wait_clk(3);
    endtask
endmodule
`default_nettype wire

// ===== sim/tb_adc_result_readout_chain.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) bad_msg(48'(g), 48'(e)); end
module tb_adc_result_readout_chain;
    localparam int OSC = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic convert_start_n = 1'b1;
    logic chain_enable_bit = 1'b1;
    logic tag_enable_bit = 1'b0;
    logic manual_trigger_bit = 1'b1;
    logic osc_clock_bit = 1'b0;
    logic software_reset_bit = 1'b1;
    logic result_valid = 1'b0;
    logic [16:0] result_code = 17'h00000;
    logic result_channel = 1'b0;
    wire logic frame_n, sclk, chain_data_in, status_in, status_out, status_oe_n;
    wire logic sdo_out, sdo_oe_n, result_ready, sampling_end;
    int n_fail = 0;
    int compares = 0;
    int held = 32'h0000FFFF;
    int q[$];
    bit first = 1'b1;
    logic [47:0] got;
    logic [16:0] codes [4] = '{17'h00000, 17'h08000, 17'h0FFFF, 17'h10000};
    int seed_val;
    int cnt;
    int n_eos = 0;

    initial begin
        forever #50 clk = ~clk;
    end
    // Pulse counter lets a check span a whole read
    always @(posedge clk) begin
        if (sampling_end === 1'b1) n_eos <= n_eos + 1;
    end
    assign status_in = status_oe_n ? chain_data_in : status_out;
    acr_host_model u_host (.clk(clk), .frame_n(frame_n), .sclk(sclk), .cdi_drive(chain_data_in),
        .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n));
    acr_readout #(.FIFO_DEPTH(acr_pkg::FIFO_DEPTH), .OSC_DIV(OSC)) u_dut (.clk(clk),
        .rst(rst), .sclk(sclk), .frame_sync_input(frame_n), .convert_start_n(convert_start_n),
        .status_in(status_in), .status_out(status_out), .status_oe_n(status_oe_n),
        .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .chain_enable_bit(chain_enable_bit),
        .tag_enable_bit(tag_enable_bit), .manual_trigger_bit(manual_trigger_bit),
        .osc_clock_bit(osc_clock_bit), .software_reset_bit(software_reset_bit),
        .result_valid(result_valid), .result_ready(result_ready), .result_code(result_code),
        .result_channel(result_channel), .sampling_end(sampling_end));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic bad_msg(input logic [47:0] g, input logic [47:0] e);
        n_fail++;
        $display("BAD %0t got %0h expected %0h", $time, g, e);
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    // Valid drops for a cycle between pushes so it is never driven twice at once
    task automatic push(input logic [16:0] code, input logic ch);
        int v;
        v = {15'h0000, ch, (code[16] ? 16'hFFFF : code[15:0])};
        if (result_ready === 1'b1) q.push_back(v);
        result_code = code;
        result_channel = ch;
        result_valid = 1'b1;
        tick(1);
        result_valid = 1'b0;
        tick(1);
    endtask
    // Long idle gap lets the buffer drain into the held result
    task automatic settle();
        tick(acr_pkg::FIFO_DEPTH + 4);
        if (q.size() > 0) begin
            held = q[$];
            if (chain_enable_bit) `CHK(status_out, 1'b1)
        end
        q.delete();
    endtask
    task automatic read(input int n, input logic [47:0] cdi_v, input int n_mid);
        logic [23:0] w;
        logic [47:0] e;
        w = {held[15:0], tag_enable_bit & held[16], 7'h00};
        if (first) e = '1;
        else if (chain_enable_bit) e = {w, 24'h000000};
        else if (tag_enable_bit) e = {w, cdi_v[47:24]};
        else e = {w[23:8], cdi_v[47:32], 16'h0000};
        u_host.frame_start();
        `CHK(sdo_oe_n, 1'b0)
        `CHK(status_oe_n, ~chain_enable_bit)
        `CHK(status_out, 1'b0)
        for (int i = 0; i < n_mid; i++) push({1'b0, 16'($urandom)}, 1'($urandom));
        if (n_mid > acr_pkg::FIFO_DEPTH) `CHK(result_ready, 1'b0)
        u_host.shift(n, cdi_v, got);
        `CHK(got >> (48 - n), e >> (48 - n))
        u_host.frame_stop();
        `CHK({sdo_oe_n, sdo_out}, 2'b10)
        first = 1'b0;
        settle();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed_val = $urandom(32'h5f23f8ad);
        tick(20);
        rst = 1'b0;
        read(16, '0, 0);
        for (int t = 0; t < 2; t++) begin
            tag_enable_bit = t[0];
            for (int i = 0; i < 6; i++) begin
                push(i < 4 ? codes[i] : {1'b0, 16'($urandom)}, 1'($urandom));
                settle();
                read(t ? 24 : 16, '0, 0);
            end
        end
        read(4, '0, 0);
        read(16, '0, 1);
        read(16, '0, 0);
        read(16, '0, acr_pkg::FIFO_DEPTH + 1);
        read(16, '0, 0);
        chain_enable_bit = 1'b0;
        tick(2);
        for (int t = 0; t < 2; t++) begin
            tag_enable_bit = t[0];
            read(t ? 48 : 32, {16'($urandom), 32'($urandom)}, 0);
            read(16, {16'($urandom), 32'($urandom)}, 0);
        end
        chain_enable_bit = 1'b1;
        tag_enable_bit = 1'b0;
        software_reset_bit = 1'b0;
        tick(2);
        software_reset_bit = 1'b1;
        held = 32'h0000FFFF;
        first = 1'b1;
        q.delete();
        tick(2);
        read(16, '0, 0);
        `CHK(sampling_end, 1'b0)
        convert_start_n = 1'b0;
        tick(1);
        `CHK(sampling_end, 1'b1)
        tick(1);
        `CHK(sampling_end, 1'b0)
        convert_start_n = 1'b1;
        tick(1);
        `CHK(sampling_end, 1'b0)
        manual_trigger_bit = 1'b0;
        osc_clock_bit = 1'b1;
        tick(1);
        push(17'h01234, 1'b1);
        cnt = 1;
        while (sampling_end !== 1'b1 && cnt < 40) begin
            tick(1);
            cnt++;
        end
        `CHK(cnt >= 2 * OSC && cnt <= 3 * OSC + 2, 1'b1)
        settle();
        read(16, '0, 0);
        // Serial-clock conversion clock only ticks while the host clocks a read
        osc_clock_bit = 1'b0;
        cnt = n_eos;
        push({1'b0, 16'($urandom)}, 1'($urandom));
        settle();
        `CHK(n_eos - cnt, 0)
        read(16, '0, 0);
        `CHK(n_eos - cnt, 1)
        give_verdict();
    end
    // About 4,700 cycles are expected; the limit leaves ample margin
    initial begin
        tick(60000);
        n_fail++;
        give_verdict();
    end
endmodule
`default_nettype wire
